/* File: hw/lil_consts.vh */
// Purpose: Constants for the LED indicator logic block.
// Assumes: 32-bit AXI4-Lite register bus, 10 MHz system clock.
// Notes:   Offsets are byte addresses; fields are bit positions.
`ifndef LIL_CONSTS_VH
`define LIL_CONSTS_VH

// Register byte offsets.
`define LIL_OFS_ASSIGN    4'h0
`define LIL_OFS_CONFIG    4'h4
`define LIL_OFS_STATUS    4'h8

// Assignment register: five 6-bit slots, bit 5 of a slot enables it.
`define LIL_SLOT_W        6
`define LIL_SLOT_EN       5
`define LIL_ASSIGN_RST    32'h0000_0000

// Config register fields.
`define LIL_CFG_INV_LSB   0
`define LIL_CFG_LATCH     8
`define LIL_CFG_ACK_LSB   16
`define LIL_CFG_ACK_EN    21
`define LIL_CFG_ACT_LSB   24
`define LIL_CFG_INACT_LSB 28
`define LIL_CFG_RST       32'h4100_0000

// Colour settings.
`define LIL_COL_GREEN     3'h0
`define LIL_COL_RED       3'h1
`define LIL_COL_RED_FL    3'h2
`define LIL_COL_GREEN_FL  3'h3
`define LIL_COL_OFF       3'h4

// Flash timing: half period in milliseconds and clock rate in Hz.
`define LIL_FLASH_HALF_MS 250
`define LIL_CLK_HZ        10000000
`define LIL_FLASH_CYC     (`LIL_CLK_HZ / 1000 * `LIL_FLASH_HALF_MS)

// AXI responses.
`define LIL_RESP_OKAY     2'h0
`define LIL_RESP_SLVERR   2'h2
`endif

/* File: hw/lil_led_indicator.v */
// Purpose: One front-panel LED: five selectable, invertible status inputs
//          ORed together, colour or flash per state, optional latch with
//          acknowledge, configured over AXI4-Lite.
// Assumes: Status inputs come from logic on SYS_CLK and need no synchroniser.
// Notes:   The rules that this block keeps are listed below.
// Overview of operation
// (RL1) Each assigned input may be inverted before the OR; default is off.
// (RL2) OR true drives the active colour setting, red by default.
// (RL3) OR false drives the inactive colour setting, off by default.
// (RL4) Settings: steady green, steady red, flashing red, flashing green, off.
// (RL5) With latch enabled the LED holds active after pick-up; default off.
// (RL6) An acknowledge input is selected from the assignable status signals.
// (RL7) The acknowledge acts only while the latch option is enabled.
// (RL8) Acknowledge clears the latch only once the causing inputs have gone.
// (RL9) Flashing settings toggle the LED at a fixed clock-derived rate.
// (RL10) Reset clears the latch; the LED then follows the live condition.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "lil_consts.vh"

module lil_led_indicator
#(
  parameter FLASH_CYC = `LIL_FLASH_CYC
)
(
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire [31:0] STATUS_IN,
  input  wire [3:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [3:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg         LED_RED,
  output reg         LED_GREEN
);

  reg  [31:0] assign_r;
  reg  [31:0] config_r;
  reg         latched_r;
  reg  [22:0] flash_cnt_r;
  reg         flash_ph_r;
  reg         aw_held_r;
  reg         w_held_r;
  reg  [3:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg  [4:0]  sig_bits;
  reg         comb_on;
  reg         ack_sig;
  reg         led_on;
  reg  [2:0]  colour;
  reg  [1:0]  led_nxt;
  reg  [31:0] rd_nxt;
  integer     i;

  wire        latch_en = config_r[`LIL_CFG_LATCH];
  wire        do_write = aw_held_r & w_held_r & ~S_AXI_BVALID;

  // Byte-lane merge used by both writable registers.
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
    end
  endfunction

  // Offset decode; a miss answers SLVERR.
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `LIL_OFS_ASSIGN) | (a == `LIL_OFS_CONFIG) |
               (a == `LIL_OFS_STATUS);
    end
  endfunction

  // Gather the five slots; a disabled slot contributes nothing to the OR.
  always @*
  begin
    for (i = 0; i < 5; i = i + 1)
      sig_bits[i] = assign_r[i*`LIL_SLOT_W + `LIL_SLOT_EN] &
        (STATUS_IN[assign_r[i*`LIL_SLOT_W +: 5]] ^
         config_r[`LIL_CFG_INV_LSB + i]);                  // [RL1]
    comb_on = |sig_bits;
    ack_sig = config_r[`LIL_CFG_ACK_EN] &
              STATUS_IN[config_r[`LIL_CFG_ACK_LSB +: 5]];   // [RL6]
    led_on  = comb_on | latched_r;                          // [RL5]
    colour  = led_on ? config_r[`LIL_CFG_ACT_LSB +: 3]      // [RL2]
                     : config_r[`LIL_CFG_INACT_LSB +: 3];   // [RL3]
    case (colour)                                           // [RL4]
      `LIL_COL_GREEN:    led_nxt = 2'b01;
      `LIL_COL_RED:      led_nxt = 2'b10;
      `LIL_COL_RED_FL:   led_nxt = {flash_ph_r, 1'b0};      // [RL9]
      `LIL_COL_GREEN_FL: led_nxt = {1'b0, flash_ph_r};      // [RL9]
      default:           led_nxt = 2'b00;
    endcase
  end

  // Latch: a live condition keeps it set, so set always wins over an
  // acknowledge arriving in the same cycle.
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
      latched_r <= 1'b0;                                    // [RL10]
    else if (!latch_en)
      latched_r <= 1'b0;                                    // [RL7]
    else if (comb_on)
      latched_r <= 1'b1;                                    // [RL5]
    else if (ack_sig)
      latched_r <= 1'b0;                                    // [RL8]
  end

  // Free-running flash timer; both flash settings share one phase so
  // several LEDs built from this block blink in step.
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      flash_cnt_r <= 23'h0;
      flash_ph_r  <= 1'b0;
    end
    else if (flash_cnt_r == FLASH_CYC[22:0] - 23'h1)
    begin
      flash_cnt_r <= 23'h0;
      flash_ph_r  <= ~flash_ph_r;                           // [RL9]
    end
    else
      flash_cnt_r <= flash_cnt_r + 23'h1;
  end

  // LED drive comes from flops so the pins never glitch.
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      LED_RED   <= 1'b0;
      LED_GREEN <= 1'b0;
    end
    else
    begin
      LED_RED   <= led_nxt[1];
      LED_GREEN <= led_nxt[0];
    end
  end

  // Write channels are taken independently and held until both arrive.
  assign S_AXI_AWREADY = ~aw_held_r;
  assign S_AXI_WREADY  = ~w_held_r;

  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 4'h0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `LIL_RESP_OKAY;
      assign_r     <= `LIL_ASSIGN_RST;
      config_r     <= `LIL_CFG_RST;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_held_r)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_r)
      begin
        w_held_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= mapped(aw_addr_r) ? `LIL_RESP_OKAY
                                          : `LIL_RESP_SLVERR;
        if (aw_addr_r == `LIL_OFS_ASSIGN)
          assign_r <= lane_merge(assign_r, w_data_r, w_strb_r);
        if (aw_addr_r == `LIL_OFS_CONFIG)
          config_r <= lane_merge(config_r, w_data_r, w_strb_r);
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // Read mux; status shows the live OR, the latch and the LED pins.
  always @*
  begin
    case (S_AXI_ARADDR)
      `LIL_OFS_ASSIGN: rd_nxt = assign_r;
      `LIL_OFS_CONFIG: rd_nxt = config_r;
      `LIL_OFS_STATUS: rd_nxt = {28'h0, LED_GREEN, LED_RED,
                                 latched_r, comb_on};
      default:         rd_nxt = 32'h0;
    endcase
  end

  // One read at a time: address is refused while data waits.
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= `LIL_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !S_AXI_RVALID)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_nxt;
      S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? `LIL_RESP_OKAY
                                           : `LIL_RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

endmodule

/* File: tb/lil_chk.sv */
// Purpose: Port checks for the LED indicator block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module lil_chk
(
  input wire        SYS_CLK,
  input wire        RST_N,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [3:0]  S_AXI_ARADDR,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire        LED_RED,
  input wire        LED_GREEN
);
  // Reset silences every check, so no stale value can fire one.
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  a_led_excl: assert property (!(LED_RED && LED_GREEN))
    else $error("two colours lit");
  a_reset_dark: assert property (
    $rose(RST_N) |-> !LED_RED && !LED_GREEN)
    else $error("LED lit after reset");
  a_bvalid_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped");
  a_bvalid_drop: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data moved");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  a_unmapped_err: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= 4'hc
    |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
    else $error("unmapped read accepted");
endmodule
bind lil_led_indicator lil_chk u_chk (.SYS_CLK, .RST_N, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .LED_RED,
  .LED_GREEN);

/* File: tb/lil_led_model.sv */
// Purpose: Bicolour panel LED watched by a light sensor.
// Assumes: Pins are active high and sampled on the system clock.
// Notes:   Lit cycles are summed, so flash duty shows as well.
`timescale 1ns/1ps
module lil_led_model
(
  input  wire        clk,
  input  wire        clr,
  input  wire        red,
  input  wire        green,
  output logic [7:0] red_cnt,
  output logic [7:0] green_cnt
);
  // A clear opens a new measurement window.
  always @(posedge clk)
  begin
    red_cnt   <= clr ? 8'h0 : red_cnt + {7'h0, red};
    green_cnt <= clr ? 8'h0 : green_cnt + {7'h0, green};
  end
endmodule

/* File: tb/lil_led_indicator_tb_top.sv */
// Purpose: Self-checking bench for the LED indicator block.
// Assumes: Flash half period shortened to four clocks.
// Notes:   Read results are matched in order from a queue.
`timescale 1ns/1ps
`include "lil_consts.vh"
module lil_led_indicator_tb_top;
  logic [31:0] sts, wd, rdata, seed;
  logic [3:0]  awa, ara, strb;
  logic [1:0]  rresp, bresp;
  logic        sys_clk, rst_n, awv, wv, bready, arv, rready, clr;
  logic        awr, wrdy, bvalid, arr, rvalid, red, green;
  logic [7:0]  rc, gc;
  logic [33:0] q[$];
  logic [1:0]  qb[$];
  int          error_cnt, n_checks, cyc, b;
  lil_led_indicator #(.FLASH_CYC(4)) dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .STATUS_IN(sts), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .LED_RED(red), .LED_GREEN(green));
  lil_led_model led (.clk(sys_clk), .clr(clr), .red(red), .green(green),
    .red_cnt(rc), .green_cnt(gc));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [33:0] seen, input logic [33:0] exp, input string n);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Ready stays high, so each answer is taken at the edge it is seen.
  task wr(input logic [3:0] a, input logic [31:0] d);
    qb.push_back(a > `LIL_OFS_STATUS ? `LIL_RESP_SLVERR : `LIL_RESP_OKAY);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end while (!bvalid);
  endtask
  task rd(input logic [3:0] a, input logic [33:0] exp);
    q.push_back(exp);
    ara <= a;
    arv <= 1'b1;
    do
      @(posedge sys_clk);
    while (!arr);
    arv <= 1'b0;
    do
      @(posedge sys_clk);
    while (!rvalid);
  endtask
  // Watched bit b carries the condition, bit b+16 the acknowledge.
  task src(input logic v, input logic k);
    seed = lfsr(seed);
    sts <= seed & ~(32'h1 << b) & ~(32'h1 << (b + 16))
           | {31'h0, v} << b | {31'h0, k} << (b + 16);
    repeat (3) @(posedge sys_clk);
  endtask
  task look(input logic [15:0] exp);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    chk({rc, gc}, exp, "light");
    @(posedge sys_clk);
  endtask
  function automatic logic [15:0] lit(input int c);
    return c == 0 ? 16'h0010 : c == 1 ? 16'h1000 : c == 2 ? 16'h0800 :
           c == 3 ? 16'h0008 : 16'h0000;
  endfunction
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Results are compared in issue order as they come back.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (rvalid && rready)
      chk({rresp, rdata}, q.pop_front(), "read");
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, qb.pop_front()}, "bresp");
    if (cyc == 5000)
    begin
      error_cnt++;
      give_verdict;
    end
  end
  initial
  begin
    {rst_n, awv, wv, arv, clr} = 5'h0;
    {bready, rready, strb} = 6'h3f;
    {sts, wd, awa, ara} = 72'h0;
    seed = lfsr(32'h43);
    b = seed[3:0];
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`LIL_OFS_ASSIGN, {2'h0, `LIL_ASSIGN_RST});
    rd(`LIL_OFS_CONFIG, {2'h0, `LIL_CFG_RST});
    rd(4'hc, {`LIL_RESP_SLVERR, 32'h0});
    wr(4'hc, 32'hffff_ffff);
    strb <= 4'h8;
    wr(`LIL_OFS_CONFIG, 32'h0000_00ff);
    strb <= 4'hf;
    rd(`LIL_OFS_CONFIG, 34'h0);
    wr(`LIL_OFS_CONFIG, `LIL_CFG_RST);
    rd(`LIL_OFS_CONFIG, {2'h0, `LIL_CFG_RST});
    wr(`LIL_OFS_ASSIGN, 32'h20 | 32'(b));
    src(1'b1, 1'b0);
    rd(`LIL_OFS_STATUS, 34'h5);
    wr(`LIL_OFS_CONFIG, `LIL_CFG_RST | 32'h1);
    rd(`LIL_OFS_STATUS, 34'h0);
    for (int c = 0; c < 5; c++)
    begin
      wr(`LIL_OFS_CONFIG, 32'((4 - c) << 28 | c << 24));
      src(1'b1, 1'b0);
      look(lit(c));
      src(1'b0, 1'b0);
      look(lit(4 - c));
    end
    wr(`LIL_OFS_CONFIG, `LIL_CFG_RST | 32'h20_0100 | 32'(b + 16) << 16);
    src(1'b1, 1'b0);
    src(1'b0, 1'b0);
    rd(`LIL_OFS_STATUS, 34'h6);
    src(1'b1, 1'b1);
    rd(`LIL_OFS_STATUS, 34'h7);
    src(1'b0, 1'b1);
    rd(`LIL_OFS_STATUS, 34'h0);
    src(1'b1, 1'b0);
    src(1'b0, 1'b0);
    wr(`LIL_OFS_CONFIG, `LIL_CFG_RST | 32'h20_0000 | 32'(b + 16) << 16);
    src(1'b0, 1'b0);
    rd(`LIL_OFS_STATUS, 34'h0);
    src(1'b1, 1'b1);
    rd(`LIL_OFS_STATUS, 34'h5);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`LIL_OFS_STATUS, 34'h0);
    give_verdict;
  end
endmodule
